// *** rtl/spfc_end_match.sv ***
`timescale 1ns/1ps
`default_nettype none
module spfc_end_match #(
  parameter int W = 13
) (
  // Pointer and buffer end
  input  wire logic [W-1:0] ptr,
  input  wire logic [W-1:0] end_addr,
  input  wire logic [1:0]   mode,
  // Decoded end actions
  output logic              hit,
  output logic              chain_hit,
  output logic              stop_hit
);
  import spfc_pkg::*;

  // Equality compare and mode decode for one buffer
  always_comb begin
    hit       = (ptr == end_addr);
    chain_hit = hit && (mode == SPFC_CHAIN);
    stop_hit  = hit && (mode == SPFC_STOP);
  end
endmodule
`default_nettype wire

// *** rtl/spfc_pkg.sv ***
package spfc_pkg;
  localparam int          PTR_W        = 13;
  localparam int          DATA_W       = 16;
  // Command address codes
  localparam logic [2:0]  CMD_START1   = 3'h0;
  localparam logic [2:0]  CMD_END1     = 3'h1;
  localparam logic [2:0]  CMD_START2   = 3'h2;
  localparam logic [2:0]  CMD_END2     = 3'h3;
  localparam logic [2:0]  CMD_FLOW     = 3'h4;
  localparam logic [2:0]  CMD_STATUS   = 3'h5;
  // Flow control register fields
  localparam int          FLOW_M1_LSB  = 0;
  localparam int          FLOW_M2_LSB  = 2;
  localparam int          FLOW_REL_BIT = 4;
  // Status register fields
  localparam int          STAT_F1_BIT  = 0;
  localparam int          STAT_F2_BIT  = 1;
  // Values after reset
  localparam logic [12:0] RST_PTR      = 13'h0000;
  localparam logic [12:0] RST_START1   = 13'h0000;
  localparam logic [12:0] RST_END1     = 13'h0FFF;
  localparam logic [12:0] RST_START2   = 13'h1000;
  localparam logic [12:0] RST_END2     = 13'h1FFF;
  localparam logic [15:0] RD_FILL      = 16'hFFFF;

  typedef enum logic [1:0] {
    SPFC_CHAIN  = 2'h0,
    SPFC_STOP   = 2'h1,
    SPFC_LINEAR = 2'h2,
    SPFC_MASK   = 2'h3
  } spfc_mode_t;
endpackage

// *** rtl/spfc_pointer_flow.sv ***
`timescale 1ns/1ps
`default_nettype none
module spfc_pointer_flow #(
  parameter int PW = 13
) (
  // Clock, reset, enable
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  // Random port command access
  input  wire logic                      cmd_n,
  input  wire logic                      chip_en,
  input  wire logic                      rd_wr,
  input  wire logic [2:0]                cmd_addr,
  input  wire logic [spfc_pkg::DATA_W-1:0] io_in,
  output logic      [spfc_pkg::DATA_W-1:0] io_out,
  output logic                           io_oe,
  // Sequential side control
  input  wire logic                      count_enable_n,
  input  wire logic                      pointer_load_n,
  input  wire logic                      jump_start_first_n,
  input  wire logic                      jump_start_second_n,
  input  wire logic [PW-1:0]             seq_load_data,
  // Sequential side status
  output logic [PW-1:0]                  seq_pointer,
  output logic                           seq_write_allow,
  output logic                           end_flag_first_buffer_n,
  output logic                           end_flag_second_buffer_n
);
  import spfc_pkg::*;

  logic [PW-1:0] ptr_reg;
  logic [PW-1:0] ptr_next;
  logic [PW-1:0] start1_reg;
  logic [PW-1:0] end1_reg;
  logic [PW-1:0] start2_reg;
  logic [PW-1:0] end2_reg;
  logic [PW-1:0] load_data_reg;
  logic          load_pend_reg;
  logic [1:0]    mode1_reg;
  logic [1:0]    mode2_reg;
  logic          halted_reg;
  logic          halt_set;
  logic [1:0]    flag_reg;
  logic          hit1;
  logic          hit2;
  logic          chain1;
  logic          chain2;
  logic          stop1;
  logic          stop2;
  logic          acc;
  logic          acc_wr;
  logic          acc_rd;
  logic          counting;
  logic          release_req;
  logic [DATA_W-1:0] rd_data;

  // Command access decode: synchronous single-cycle access
  assign acc      = !cmd_n && chip_en;
  assign acc_wr   = acc && !rd_wr;
  assign acc_rd   = acc && rd_wr;
  assign counting = !count_enable_n;

  // Writing zero to the release bit frees the stopped pointer
  assign release_req = acc_wr && (cmd_addr == CMD_FLOW) && !io_in[FLOW_REL_BIT];

  // One compare unit per buffer
  spfc_end_match #(.W(PW)) u_match1 (
    .ptr       (ptr_reg),
    .end_addr  (end1_reg),
    .mode      (mode1_reg),
    .hit       (hit1),
    .chain_hit (chain1),
    .stop_hit  (stop1)
  );

  spfc_end_match #(.W(PW)) u_match2 (
    .ptr       (ptr_reg),
    .end_addr  (end2_reg),
    .mode      (mode2_reg),
    .hit       (hit2),
    .chain_hit (chain2),
    .stop_hit  (stop2)
  );

  // Next pointer: load, jumps, halt, then end-of-buffer flow
  always_comb begin
    ptr_next = ptr_reg;
    halt_set = 1'b0;
    if (load_pend_reg) begin
      ptr_next = load_data_reg;
    end else if (!pointer_load_n) begin
      ptr_next = ptr_reg;                                // Count ignored while loading
    end else if (!jump_start_first_n) begin
      ptr_next = start1_reg;
    end else if (!jump_start_second_n) begin
      ptr_next = start2_reg;
    end else if (halted_reg && !release_req) begin
      ptr_next = ptr_reg;
    end else if (counting) begin
      if (chain2) begin
        ptr_next = start1_reg;
      end else if (chain1) begin
        ptr_next = start2_reg;
      end else begin
        // Linear, mask, or stop stepping to end plus one; after release this gives end plus two
        ptr_next = ptr_reg + 1'b1;
        halt_set = stop1 || stop2;
      end
    end else begin
      halt_set = stop1 || stop2;                         // Halt on the end address itself
    end
  end

  // Pointer register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ptr_reg <= RST_PTR;
    end else if (clk_en) begin
      ptr_reg <= ptr_next;
    end
  end

  // Load holds data one cycle; the pointer changes on the following edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      load_pend_reg <= 1'b0;
      load_data_reg <= RST_PTR;
    end else if (clk_en) begin
      load_pend_reg <= !pointer_load_n && !load_pend_reg;
      if (!pointer_load_n && !load_pend_reg) begin
        load_data_reg <= seq_load_data;
      end
    end
  end

  // Halt state: a new stop wins over a release in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      halted_reg <= 1'b0;
    end else if (clk_en) begin
      if (halt_set && !load_pend_reg) begin
        halted_reg <= 1'b1;
      end else if (release_req || load_pend_reg || !pointer_load_n
                   || !jump_start_first_n || !jump_start_second_n) begin
        halted_reg <= 1'b0;
      end
    end
  end

  // Start and end address registers, 13 bits on the low data lines
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      start1_reg <= RST_START1;
      end1_reg   <= RST_END1;
      start2_reg <= RST_START2;
      end2_reg   <= RST_END2;
    end else if (clk_en && acc_wr) begin
      unique case (cmd_addr)
        CMD_START1: start1_reg <= io_in[PW-1:0];
        CMD_END1:   end1_reg   <= io_in[PW-1:0];
        CMD_START2: start2_reg <= io_in[PW-1:0];
        CMD_END2:   end2_reg   <= io_in[PW-1:0];
        default: begin
        end
      endcase
    end
  end

  // Flow mode register; bit 4 is an action, not storage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode1_reg <= SPFC_CHAIN;
      mode2_reg <= SPFC_CHAIN;
    end else if (clk_en && acc_wr && cmd_addr == CMD_FLOW) begin
      mode1_reg <= io_in[FLOW_M1_LSB +: 2];
      mode2_reg <= io_in[FLOW_M2_LSB +: 2];
    end
  end

  // Sticky status bits: a match sets, a zero written clears, set wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_reg <= 2'h0;
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0) ? hit1 : hit2) begin
          flag_reg[i] <= 1'b1;
        end else if (acc_wr && cmd_addr == CMD_STATUS && !io_in[i]) begin
          flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Read mux: unused bits and reserved codes read high
  always_comb begin
    rd_data = RD_FILL;
    unique case (cmd_addr)
      CMD_START1: rd_data[PW-1:0] = start1_reg;
      CMD_END1:   rd_data[PW-1:0] = end1_reg;
      CMD_START2: rd_data[PW-1:0] = start2_reg;
      CMD_END2:   rd_data[PW-1:0] = end2_reg;
      CMD_FLOW: begin
        rd_data[FLOW_M1_LSB +: 2] = mode1_reg;
        rd_data[FLOW_M2_LSB +: 2] = mode2_reg;
        rd_data[FLOW_REL_BIT]     = halted_reg;
      end
      CMD_STATUS: begin
        rd_data[STAT_F1_BIT] = flag_reg[0];
        rd_data[STAT_F2_BIT] = flag_reg[1];
      end
      default: rd_data = RD_FILL;
    endcase
  end

  // Registered read data; drives the bus the cycle after a read is taken
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      io_out <= RD_FILL;
      io_oe  <= 1'b0;
    end else if (clk_en) begin
      io_oe <= acc_rd;
      if (acc_rd) begin
        io_out <= rd_data;
      end
    end
  end

  // Outputs from flops; mask mode keeps the pin high though status is set
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seq_pointer              <= RST_PTR;
      seq_write_allow          <= 1'b1;
      end_flag_first_buffer_n  <= 1'b1;
      end_flag_second_buffer_n <= 1'b1;
    end else if (clk_en) begin
      seq_pointer     <= ptr_next;
      // A release reopens writes on the edge that takes it; a jump or load reopens them one edge later
      seq_write_allow <= !(halted_reg || halt_set) || release_req;
      end_flag_first_buffer_n  <= !((flag_reg[0] || hit1) && mode1_reg != SPFC_MASK
                                    && !(acc_wr && cmd_addr == CMD_STATUS && !io_in[0] && !hit1));
      end_flag_second_buffer_n <= !((flag_reg[1] || hit2) && mode2_reg != SPFC_MASK
                                    && !(acc_wr && cmd_addr == CMD_STATUS && !io_in[1] && !hit2));
    end
  end
endmodule
`default_nettype wire

// *** verif/spfc_flow_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module spfc_flow_checker #(
  parameter int PW = 13
) (
  // Clock and reset
  input wire logic                          ref_clk,
  input wire logic                          rst,
  input wire logic                          clk_en,
  // Command port
  input wire logic                          cmd_n,
  input wire logic                          chip_en,
  input wire logic                          rd_wr,
  input wire logic [2:0]                    cmd_addr,
  input wire logic [spfc_pkg::DATA_W-1:0]   io_out,
  input wire logic                          io_oe,
  // Sequential side
  input wire logic                          pointer_load_n,
  input wire logic [PW-1:0]                 seq_load_data,
  input wire logic [PW-1:0]                 seq_pointer,
  input wire logic                          end_flag_first_buffer_n,
  input wire logic                          end_flag_second_buffer_n
);
  import spfc_pkg::*;
  // A read is taken only on an enabled edge with command mode selected
  logic rd_acc;
  assign rd_acc = clk_en && !cmd_n && chip_en && rd_wr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (rd_acc |=> io_oe)
    else $error("read not answered");
  // While the enable is low the answer flop simply holds its last value
  a_oe_cause: assert property (io_oe |-> $past(rd_acc) || (!$past(clk_en) && $past(io_oe)))
    else $error("read enable without read");
  a_addr_fill: assert property (rd_acc && cmd_addr <= CMD_END2 |=> io_out[15:13] == 3'h7)
    else $error("address read upper bits low");
  a_flow_fill: assert property (rd_acc && cmd_addr == CMD_FLOW |=> io_out[15:5] == 11'h7FF)
    else $error("flow read upper bits low");
  a_status_fill: assert property (rd_acc && cmd_addr == CMD_STATUS |=> io_out[15:2] == 14'h3FFF)
    else $error("status read upper bits low");
  a_reserved_high: assert property (rd_acc && cmd_addr[2:1] == 2'h3 |=> io_out == RD_FILL)
    else $error("reserved read not all ones");
  a_reset_state: assert property ($fell(rst) |-> seq_pointer == RST_PTR && !io_oe
    && end_flag_first_buffer_n && end_flag_second_buffer_n) else $error("bad state after reset");
  a_load_two: assert property (clk_en && !pointer_load_n ##1 clk_en
    |=> seq_pointer == $past(seq_load_data, 2)) else $error("pointer load missed");
endmodule
bind spfc_pointer_flow spfc_flow_checker #(.PW(PW)) u_chk (
  .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .cmd_n(cmd_n), .chip_en(chip_en),
  .rd_wr(rd_wr), .cmd_addr(cmd_addr), .io_out(io_out), .io_oe(io_oe),
  .pointer_load_n(pointer_load_n), .seq_load_data(seq_load_data), .seq_pointer(seq_pointer),
  .end_flag_first_buffer_n(end_flag_first_buffer_n),
  .end_flag_second_buffer_n(end_flag_second_buffer_n));
`default_nettype wire

// *** verif/spfc_seq_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spfc_seq_model (
  // Clock and bench requests
  input  wire logic ref_clk,
  input  wire logic run,
  input  wire logic jump,
  input  wire logic jump2,
  input  wire logic load,
  // Active-low sequential controls
  output logic      count_enable_n = 1'b1,
  output logic      jump_start_first_n = 1'b1,
  output logic      jump_start_second_n = 1'b1,
  output logic      pointer_load_n = 1'b1
);
  // Registered so pins move just after an edge; counting stays on across a release
  always @(posedge ref_clk) begin
    count_enable_n <= !run;
  end
  // A jump is held off during a load and the cycle after it
  always @(posedge ref_clk) begin
    pointer_load_n      <= !load;
    jump_start_first_n  <= !(jump && !load && pointer_load_n);
    jump_start_second_n <= !(jump2 && !jump && !load && pointer_load_n);
  end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spfc_pkg::*;
  logic              ref_clk = 1'b0, rst = 1'b1, cmd_n = 1'b1, chip_en = 1'b0, rd_wr = 1'b1;
  logic [2:0]        cmd_addr = 3'h0;
  logic [DATA_W-1:0] io_in = 16'h0000, io_out;
  logic              io_oe, run = 1'b0, jump = 1'b0, jump2 = 1'b0, load = 1'b0;
  logic              clk_en = 1'b1;
  logic              cnt_n, jmp1_n, jmp2_n, ld_n, wr_ok, flag1_n, flag2_n;
  logic [PTR_W-1:0]  ptr;
  int                fails = 0, n_checks = 0, cycles = 0;
  logic [15:0]       rst_rd [7] = '{16'hE000, 16'hEFFF, 16'hF000, 16'hFFFF, 16'hFFE0,
                                    16'hFFFC, 16'hFFFF};
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // The run needs little more than a hundred cycles; the ceiling leaves a wide margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("MISMATCH t=%0t timeout", $time);
      report_and_stop();
    end
  end
  spfc_pointer_flow #(.PW(PTR_W)) DUT (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .cmd_n(cmd_n), .chip_en(chip_en), .rd_wr(rd_wr), .cmd_addr(cmd_addr), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .count_enable_n(cnt_n), .pointer_load_n(ld_n),
    .jump_start_first_n(jmp1_n), .jump_start_second_n(jmp2_n), .seq_load_data(13'h0003),
    .seq_pointer(ptr), .seq_write_allow(wr_ok), .end_flag_first_buffer_n(flag1_n),
    .end_flag_second_buffer_n(flag2_n));
  spfc_seq_model u_seq (.ref_clk(ref_clk), .run(run), .jump(jump), .jump2(jump2), .load(load),
    .count_enable_n(cnt_n), .jump_start_first_n(jmp1_n), .jump_start_second_n(jmp2_n),
    .pointer_load_n(ld_n));
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk16({15'h0000, g}, {15'h0000, e});
  endtask
  // One command access: held for one edge, released at the edge that takes it
  task automatic acc(input logic rw, input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    cmd_n <= 1'b0;
    chip_en <= 1'b1;
    rd_wr <= rw;
    cmd_addr <= a;
    io_in <= d;
    @(posedge ref_clk);
    cmd_n <= 1'b1;
    chip_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] e);
    acc(1'b1, a, 16'h0000);
    chk1(io_oe, 1'b1);
    chk16(io_out, e);
  endtask
  // Polls every edge, so a value held for one cycle is still seen
  task automatic wait_ptr(input logic [PTR_W-1:0] v);
    for (int i = 0; i < 40 && ptr !== v; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk16({3'h0, ptr}, {3'h0, v});
  endtask
  task automatic pulse(input logic ld);
    @(posedge ref_clk);
    if (ld) begin
      load <= 1'b1;
    end else begin
      jump <= 1'b1;
    end
    @(posedge ref_clk);
    load <= 1'b0;
    jump <= 1'b0;
    #1;
  endtask
  // Jump to the second start address; the model turns it into one low cycle
  task automatic jump_two();
    @(posedge ref_clk);
    jump2 <= 1'b1;
    @(posedge ref_clk);
    jump2 <= 1'b0;
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    for (int k = 0; k < 7; k++) begin
      rd(3'(k), rst_rd[k]);
    end
    $display("reset values done");
    acc(1'b0, CMD_END1, 16'h0005);
    acc(1'b0, CMD_START2, 16'h0100);
    run <= 1'b1;
    wait_ptr(13'h0005);
    wait_ptr(13'h0100);
    run <= 1'b0;
    chk1(flag1_n, 1'b0);
    rd(CMD_STATUS, 16'hFFFD);
    acc(1'b0, CMD_STATUS, 16'hFFFE);
    rd(CMD_STATUS, 16'hFFFC);
    chk1(flag1_n, 1'b1);
    $display("chaining done");
    acc(1'b0, CMD_FLOW, 16'h0001);
    pulse(1'b0);
    run <= 1'b1;
    wait_ptr(13'h0006);
    rd(CMD_FLOW, 16'hFFF1);
    chk16({3'h0, ptr}, 16'h0006);
    chk1(wr_ok, 1'b0);
    acc(1'b0, CMD_FLOW, 16'h0001);
    wait_ptr(13'h0007);
    run <= 1'b0;
    $display("stop done");
    acc(1'b0, CMD_STATUS, 16'hFFFC);
    acc(1'b0, CMD_END2, 16'h000A);
    acc(1'b0, CMD_FLOW, 16'h000E);
    chk1(wr_ok, 1'b1);
    pulse(1'b0);
    run <= 1'b1;
    wait_ptr(13'h000B);
    run <= 1'b0;
    chk1(flag1_n, 1'b0);
    chk1(flag2_n, 1'b1);
    rd(CMD_STATUS, 16'hFFFF);
    $display("linear and mask done");
    acc(1'b0, CMD_END2, 16'h0005);
    acc(1'b0, CMD_FLOW, 16'h0000);
    acc(1'b0, CMD_STATUS, 16'hFFFC);
    pulse(1'b1);
    run <= 1'b1;
    wait_ptr(13'h0003);
    wait_ptr(13'h0005);
    wait_ptr(13'h0000);
    run <= 1'b0;
    chk1(flag1_n, 1'b0);
    chk1(flag2_n, 1'b0);
    $display("equal ends done");
    acc(1'b0, CMD_END2, 16'h0008);
    acc(1'b0, CMD_FLOW, 16'h0006);
    acc(1'b0, CMD_STATUS, 16'hFFFC);
    pulse(1'b0);
    run <= 1'b1;
    wait_ptr(13'h0009);
    chk1(wr_ok, 1'b0);
    chk1(flag1_n, 1'b0);
    chk1(flag2_n, 1'b0);
    jump_two();
    wait_ptr(13'h0100);
    wait_ptr(13'h0101);
    chk1(wr_ok, 1'b1);
    // Freeze the block for four edges while the far side keeps counting
    @(posedge ref_clk);
    clk_en <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk16({3'h0, ptr}, 16'h0102);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    wait_ptr(13'h0103);
    run <= 1'b0;
    $display("jump release and freeze done");
    report_and_stop();
  end
endmodule
`default_nettype wire
